/* verilog/isr_ctrl.sv */
// Two-wire bus controller with slave receive and status reporting
// Notes on behaviour
// - Own address plus write: ack, flag, 60h.
// - General call when enabled: slave receive, 70h.
// - Ten-bit: first byte acked silently.
// - Arbitration lost then addressed: 68h or 78h.
// - With ack-assert: ack each byte, 80h/90h.
// - STOP or restart after ack: flag, A0h.
// - Ack-assert cleared: nack, 88h/98h, idle after flag clear or STOP.
// - Last transmitted byte acked: C8h, idle.
// - Transmitted byte not acked: C0h, idle.
// - STOP after ack returns slave idle.
// - Hardware reset: registers 00h, status F8h.
// - Soft reset: idle, clears stop/start/flag.
// - Seven-bit address in own-address [7:1].
// - Ten-bit address is own[2:1] with extended.
// - Byte registers; status read-only; two write-only.
// - Master address read: 40h ack, 48h nack.
// - Master received byte: 50h ack, 58h nack.
// - Own address plus read: A8h, B0h after arbitration.
// - Transmitted byte acked: B8h, continue.
// - Ten-bit second address: D0h or D8h.
// - Status reads F8h while flag clear.
// - Bus error 00h; stop-request recovers silently.
`timescale 1ns/1ps
`default_nettype none
module isr_ctrl
	import isr_pkg::*;
(
	// System
	input wire logic SYS_CLK,
	input wire logic RESET,
	// Avalon-MM slave
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Bus lines
	input wire logic SCL_IN,
	output logic SCL_OUT,
	output logic SCL_OE_N,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N,
	// Processor interrupt
	output logic INTERRUPT_REQ
);
	typedef struct packed {
		isr_phase_type phase;
		logic [1:0] sub;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [7:0] sar;
		logic [7:0] xsar;
		logic [7:0] dr;
		logic [7:0] ctl;
		logic [7:0] status;
		logic [6:0] ccr;
		logic [14:0] div;
		logic master;
		logic tx;
		logic addr_ph;
		logic ten_pend;
		logic ten1;
		logic mten;
		logic hit;
		logic gc;
		logic arb;
		logic rw;
		logic ack;
		logic busy;
		logic scl_oe_n;
		logic sda_oe_n;
		logic drive_level;
		logic waitreq;
		logic [31:0] rdata;
	} isr_state_type;

	isr_state_type st;
	isr_state_type next_st;
	isr_pins_type pw;
	logic acc;
	logic wr_go;
	logic flag_clr;
	logic tick;
	logic [7:0] wd;
	logic [14:0] reload;

	isr_pin_watch u_watch (
		.clk(SYS_CLK),
		.reset(RESET),
		.scl_pin(SCL_IN),
		.sda_pin(SDA_IN),
		.pins(pw)
	);

	function automatic logic [7:0] rd_reg(input logic [7:0] a, input isr_state_type s);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			ISR_OFS_SAR: v = s.sar;
			ISR_OFS_XSAR: v = s.xsar;
			ISR_OFS_DR: v = s.dr;
			ISR_OFS_CTL: v = s.ctl;
			ISR_OFS_SR: v = s.ctl[ISR_CTL_FLAG] ? s.status : ISR_SC_NONE;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : rd_reg

	// Flag and status together, hardware set
	function automatic isr_state_type raise(input isr_state_type s, input logic [7:0] code);
		isr_state_type r;
		r = s;
		r.ctl[ISR_CTL_FLAG] = 1'b1;
		r.status = code;
		return r;
	endfunction : raise

	////////////////////////////////////////////////////////////////////////////
	assign acc = AVS_READ | AVS_WRITE;
	assign wr_go = AVS_WRITE & ~st.waitreq;
	assign wd = AVS_WRITEDATA[7:0];
	assign tick = (st.div == 15'h0000);
	assign reload = 15'(((({11'h000, st.ccr[6:3]} + 15'h0001) * ISR_DIV_BASE) << st.ccr[2:0]));

	always_comb begin
		next_st = st;
		flag_clr = 1'b0;
		// Bus slave: one stall cycle, then answer
		next_st.waitreq = ~(acc & st.waitreq);
		if (acc & st.waitreq) begin
			next_st.rdata = {24'h000000, rd_reg(AVS_ADDRESS, st)};
		end
		next_st.div = tick ? reload : 15'(st.div - 15'h0001);
		if (wr_go) begin
			case (AVS_ADDRESS)
				ISR_OFS_SAR: next_st.sar = wd;
				ISR_OFS_XSAR: next_st.xsar = wd;
				ISR_OFS_DR: next_st.dr = wd;
				ISR_OFS_CTL: begin
					next_st.ctl = wd;
					next_st.ctl[ISR_CTL_FLAG] = st.ctl[ISR_CTL_FLAG] & wd[ISR_CTL_FLAG];
					flag_clr = st.ctl[ISR_CTL_FLAG] & ~wd[ISR_CTL_FLAG];
				end
				ISR_OFS_CCR: next_st.ccr = wd[6:0];
				default: ;
			endcase
		end
		if (wr_go && AVS_ADDRESS == ISR_OFS_SRR) begin
			next_st.phase = PH_IDLE;
			next_st.ctl[ISR_CTL_START_REQ] = 1'b0;
			next_st.ctl[ISR_CTL_STOP_REQ] = 1'b0;
			next_st.ctl[ISR_CTL_FLAG] = 1'b0;
			next_st.master = 1'b0;
			next_st.scl_oe_n = 1'b1;
			next_st.sda_oe_n = 1'b1;
		end else begin
			////////////////////////////////////////////////////////////////////
			// Software releases a held transfer
			if (flag_clr) begin
				case (st.phase)
					PH_HOLD: begin
						if (st.ctl[ISR_CTL_START_REQ] && st.master) begin
							next_st.phase = PH_START;
							next_st.sub = 2'h0;
						end else if (st.ctl[ISR_CTL_STOP_REQ] && st.master) begin
							next_st.phase = PH_STOP;
							next_st.sub = 2'h0;
							next_st.sda_oe_n = 1'b0;
						end else begin
							next_st.phase = PH_BYTE;
							next_st.cnt = 4'h0;
							next_st.shift = st.dr;
							next_st.sda_oe_n = st.tx ? st.dr[7] : 1'b1;
							if (!st.master) begin
								next_st.scl_oe_n = 1'b1;
							end
						end
					end
					PH_DONE: next_st.phase = PH_IDLE;
					PH_BERR: begin
						if (st.ctl[ISR_CTL_STOP_REQ]) begin
							next_st.phase = PH_IDLE;
							next_st.ctl[ISR_CTL_STOP_REQ] = 1'b0;
						end
					end
					default: ;
				endcase
			end
			if (st.phase == PH_IDLE && st.ctl[ISR_CTL_START_REQ] && !st.busy
					&& !st.ctl[ISR_CTL_FLAG]) begin
				next_st.phase = PH_START;
				next_st.sub = 2'h0;
				next_st.master = 1'b1;
			end
			////////////////////////////////////////////////////////////////////
			// Bus conditions seen on the lines
			if (pw.start) begin
				next_st.busy = 1'b1;
			end
			if (pw.stop) begin
				next_st.busy = 1'b0;
			end
			if (st.master && (pw.start || pw.stop) && st.phase == PH_BYTE && st.cnt != 4'h0) begin
				next_st = raise(next_st, ISR_SC_BERR);
				next_st.phase = PH_BERR;
				next_st.master = 1'b0;
				next_st.scl_oe_n = 1'b1;
				next_st.sda_oe_n = 1'b1;
			end else if (!st.master && (pw.start || pw.stop)) begin
				// The condition's own SCL high may already have counted one bit
				if (st.phase == PH_BYTE && st.cnt[3:1] == 3'h0 && st.hit && !st.addr_ph && !st.tx) begin
					next_st = raise(next_st, ISR_SC_SSTOP);
				end
				next_st.hit = 1'b0;
				next_st.ten_pend = 1'b0;
				next_st.arb = 1'b0;
				next_st.sda_oe_n = 1'b1;
				next_st.scl_oe_n = 1'b1;
				if (pw.start) begin
					next_st.phase = PH_BYTE;
					next_st.cnt = 4'h0;
					next_st.addr_ph = 1'b1;
					next_st.tx = 1'b0;
				end else if (st.phase != PH_BERR) begin
					next_st.phase = PH_IDLE;
				end
			end
			////////////////////////////////////////////////////////////////////
			// Master START and STOP sequencing
			if (st.phase == PH_START && tick) begin
				next_st.sub = 2'(st.sub + 2'h1);
				case (st.sub)
					2'h0: next_st.sda_oe_n = 1'b1;
					2'h1: next_st.scl_oe_n = 1'b1;
					2'h2: next_st.sda_oe_n = 1'b0;
					default: begin
						next_st.scl_oe_n = 1'b0;
						next_st.ctl[ISR_CTL_START_REQ] = 1'b0;
						next_st = raise(next_st, ISR_SC_MSTART);
						next_st.phase = PH_HOLD;
						next_st.addr_ph = 1'b1;
						next_st.mten = 1'b0;
						next_st.tx = 1'b1;
					end
				endcase
			end
			if (st.phase == PH_STOP && tick) begin
				next_st.sub = 2'(st.sub + 2'h1);
				case (st.sub)
					2'h0: next_st.scl_oe_n = 1'b1;
					2'h1: next_st.sda_oe_n = 1'b1;
					default: begin
						next_st.phase = PH_IDLE;
						next_st.master = 1'b0;
						next_st.ctl[ISR_CTL_STOP_REQ] = 1'b0;
					end
				endcase
			end
			// Master clock generation; waits out a stretched low
			if (st.master && (st.phase == PH_BYTE || st.phase == PH_ACK) && tick) begin
				if (!st.scl_oe_n) begin
					next_st.scl_oe_n = 1'b1;
				end else if (pw.scl) begin
					next_st.scl_oe_n = 1'b0;
				end
			end
			////////////////////////////////////////////////////////////////////
			// Sampling on SCL rise
			if (pw.scl_rise && st.phase == PH_BYTE && st.cnt != 4'h8) begin
				next_st.shift = {st.shift[6:0], pw.sda};
				next_st.cnt = 4'(st.cnt + 4'h1);
				if (st.master && st.tx && st.sda_oe_n && !pw.sda) begin
					next_st.master = 1'b0;
					next_st.scl_oe_n = 1'b1;
					next_st.tx = 1'b0;
					next_st.arb = st.addr_ph;
					if (!st.addr_ph) begin
						next_st.phase = PH_IDLE;
					end
				end
			end
			if (pw.scl_rise && st.phase == PH_ACK && st.tx) begin
				next_st.ack = ~pw.sda;
			end
			////////////////////////////////////////////////////////////////////
			// Shifting out and ack decision on SCL fall
			if (pw.scl_fall && st.phase == PH_BYTE && st.cnt != 4'h8) begin
				if (st.tx) begin
					next_st.sda_oe_n = st.shift[7];
				end
			end
			if (pw.scl_fall && st.phase == PH_BYTE && st.cnt == 4'h8) begin
				next_st.phase = PH_ACK;
				next_st.rw = st.shift[0];
				next_st.ack = 1'b0;
				next_st.sda_oe_n = 1'b1;
				if (!st.tx && !st.addr_ph) begin
					next_st.dr = st.shift;
				end
				if (st.master && !st.tx) begin
					next_st.ack = st.ctl[ISR_CTL_ACK_ASSERT];
				end else if (!st.master && st.addr_ph) begin
					next_st.ten1 = 1'b0;
					next_st.gc = 1'b0;
					next_st.hit = 1'b0;
					if (st.ten_pend) begin
						next_st.hit = (st.shift == st.xsar);
						next_st.rw = 1'b0;
					end else if (st.sar[7:3] == ISR_TEN_TAG) begin
						next_st.ten1 = (st.shift[7:1] == st.sar[7:1]) && !st.shift[0];
						next_st.hit = 1'b0;
					end else begin
						next_st.hit = (st.shift[7:1] == st.sar[7:1]);
					end
					if (st.shift == 8'h00 && st.sar[ISR_SAR_GC_ENABLE]) begin
						next_st.hit = 1'b1;
						next_st.gc = 1'b1;
					end
					if (!st.ctl[ISR_CTL_ACK_ASSERT]) begin
						next_st.hit = 1'b0;
						next_st.ten1 = 1'b0;
					end
					next_st.ack = next_st.hit | next_st.ten1;
					if (!(next_st.hit | next_st.ten1)) begin
						next_st.phase = PH_IDLE;
						next_st.ten_pend = 1'b0;
						next_st.arb = 1'b0;
					end
				end else if (!st.master && !st.tx) begin
					next_st.ack = st.ctl[ISR_CTL_ACK_ASSERT];
				end
				if (!st.tx) begin
					next_st.sda_oe_n = ~next_st.ack;
				end
			end
			////////////////////////////////////////////////////////////////////
			// End of the acknowledge bit
			if (pw.scl_fall && st.phase == PH_ACK) begin
				next_st.sda_oe_n = 1'b1;
				next_st.phase = PH_HOLD;
				next_st.cnt = 4'h0;
				if (st.master && st.tx && st.addr_ph) begin
					next_st.addr_ph = 1'b0;
					if (st.mten) begin
						next_st = raise(next_st, st.ack ? ISR_SC_TEN_ACK : ISR_SC_TEN_NACK);
						next_st.mten = 1'b0;
					end else if (st.rw) begin
						next_st = raise(next_st, st.ack ? ISR_SC_MAR_ACK : ISR_SC_MAR_NACK);
						next_st.tx = 1'b0;
					end else begin
						next_st = raise(next_st, st.ack ? ISR_SC_MAW_ACK : ISR_SC_MAW_NACK);
						next_st.mten = (st.shift[7:3] == ISR_TEN_TAG);
						next_st.addr_ph = (st.shift[7:3] == ISR_TEN_TAG);
					end
				end else if (st.master && st.tx) begin
					next_st = raise(next_st, st.ack ? ISR_SC_MDW_ACK : ISR_SC_MDW_NACK);
				end else if (st.master) begin
					next_st = raise(next_st, st.ack ? ISR_SC_MDR_ACK : ISR_SC_MDR_NACK);
				end else if (st.addr_ph && st.ten1) begin
					next_st.ten_pend = 1'b1;
					next_st.phase = PH_BYTE;
				end else if (st.addr_ph) begin
					next_st.addr_ph = 1'b0;
					next_st.ten_pend = 1'b0;
					next_st.tx = st.rw;
					next_st.arb = 1'b0;
					next_st.scl_oe_n = 1'b0;
					if (st.rw) begin
						next_st = raise(next_st, st.arb ? ISR_SC_SR_ARB : ISR_SC_SR);
					end else if (st.gc) begin
						next_st = raise(next_st, st.arb ? ISR_SC_GC_ARB : ISR_SC_GC);
					end else begin
						next_st = raise(next_st, st.arb ? ISR_SC_SW_ARB : ISR_SC_SW);
					end
				end else if (!st.tx && st.ack) begin
					next_st = raise(next_st, st.gc ? ISR_SC_GD_ACK : ISR_SC_SD_ACK);
					next_st.scl_oe_n = 1'b0;
				end else if (!st.tx) begin
					next_st = raise(next_st, st.gc ? ISR_SC_GD_NACK : ISR_SC_SD_NACK);
					next_st.phase = PH_DONE;
					next_st.hit = 1'b0;
				end else if (!st.ack) begin
					next_st = raise(next_st, ISR_SC_ST_NACK);
					next_st.phase = PH_IDLE;
					next_st.hit = 1'b0;
				end else if (!st.ctl[ISR_CTL_ACK_ASSERT]) begin
					next_st = raise(next_st, ISR_SC_ST_LAST);
					next_st.phase = PH_IDLE;
					next_st.hit = 1'b0;
				end else begin
					next_st = raise(next_st, ISR_SC_ST_ACK);
					next_st.scl_oe_n = 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			st <= '{
				phase: PH_IDLE,
				sar: ISR_RST_REG,
				xsar: ISR_RST_REG,
				dr: ISR_RST_REG,
				ctl: ISR_RST_REG,
				status: ISR_RST_SR,
				scl_oe_n: 1'b1,
				sda_oe_n: 1'b1,
				waitreq: 1'b1,
				default: '0
			};
		end else begin
			st <= next_st;
		end
	end

	assign AVS_READDATA = st.rdata;
	assign AVS_WAITREQUEST = st.waitreq;
	assign SCL_OUT = st.drive_level;
	assign SCL_OE_N = st.scl_oe_n;
	assign SDA_OUT = st.drive_level;
	assign SDA_OE_N = st.sda_oe_n;
	assign INTERRUPT_REQ = st.ctl[ISR_CTL_FLAG];
endmodule : isr_ctrl
`default_nettype wire

/* verilog/isr_pkg.sv */
// Shared constants and types for the two-wire bus controller
package isr_pkg;
	// Register byte addresses
	localparam logic [7:0] ISR_OFS_SAR = 8'h00;
	localparam logic [7:0] ISR_OFS_XSAR = 8'h04;
	localparam logic [7:0] ISR_OFS_DR = 8'h08;
	localparam logic [7:0] ISR_OFS_CTL = 8'h0C;
	localparam logic [7:0] ISR_OFS_SR = 8'h10;
	localparam logic [7:0] ISR_OFS_CCR = 8'h14;
	localparam logic [7:0] ISR_OFS_SRR = 8'h18;
	// Field positions
	localparam int ISR_CTL_START_REQ = 5;
	localparam int ISR_CTL_STOP_REQ = 4;
	localparam int ISR_CTL_FLAG = 3;
	localparam int ISR_CTL_ACK_ASSERT = 2;
	localparam int ISR_SAR_GC_ENABLE = 0;
	localparam logic [4:0] ISR_TEN_TAG = 5'h1E;
	// Reset values
	localparam logic [7:0] ISR_RST_REG = 8'h00;
	localparam logic [7:0] ISR_RST_SR = 8'hF8;
	// Status codes
	localparam logic [7:0] ISR_SC_BERR = 8'h00;
	localparam logic [7:0] ISR_SC_MSTART = 8'h08;
	localparam logic [7:0] ISR_SC_MAW_ACK = 8'h18;
	localparam logic [7:0] ISR_SC_MAW_NACK = 8'h20;
	localparam logic [7:0] ISR_SC_MDW_ACK = 8'h28;
	localparam logic [7:0] ISR_SC_MDW_NACK = 8'h30;
	localparam logic [7:0] ISR_SC_MAR_ACK = 8'h40;
	localparam logic [7:0] ISR_SC_MAR_NACK = 8'h48;
	localparam logic [7:0] ISR_SC_MDR_ACK = 8'h50;
	localparam logic [7:0] ISR_SC_MDR_NACK = 8'h58;
	localparam logic [7:0] ISR_SC_SW = 8'h60;
	localparam logic [7:0] ISR_SC_SW_ARB = 8'h68;
	localparam logic [7:0] ISR_SC_GC = 8'h70;
	localparam logic [7:0] ISR_SC_GC_ARB = 8'h78;
	localparam logic [7:0] ISR_SC_SD_ACK = 8'h80;
	localparam logic [7:0] ISR_SC_SD_NACK = 8'h88;
	localparam logic [7:0] ISR_SC_GD_ACK = 8'h90;
	localparam logic [7:0] ISR_SC_GD_NACK = 8'h98;
	localparam logic [7:0] ISR_SC_SSTOP = 8'hA0;
	localparam logic [7:0] ISR_SC_SR = 8'hA8;
	localparam logic [7:0] ISR_SC_SR_ARB = 8'hB0;
	localparam logic [7:0] ISR_SC_ST_ACK = 8'hB8;
	localparam logic [7:0] ISR_SC_ST_NACK = 8'hC0;
	localparam logic [7:0] ISR_SC_ST_LAST = 8'hC8;
	localparam logic [7:0] ISR_SC_TEN_ACK = 8'hD0;
	localparam logic [7:0] ISR_SC_TEN_NACK = 8'hD8;
	localparam logic [7:0] ISR_SC_NONE = 8'hF8;
	// Half-bit divider base, in system clocks
	localparam logic [14:0] ISR_DIV_BASE = 15'h000A;

	typedef enum logic [3:0] {
		PH_IDLE = 4'b0000,
		PH_BYTE = 4'b0001,
		PH_ACK = 4'b0010,
		PH_HOLD = 4'b0011,
		PH_START = 4'b0100,
		PH_STOP = 4'b0101,
		PH_BERR = 4'b0110,
		PH_DONE = 4'b0111
	} isr_phase_type;

	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} isr_pins_type;

	typedef struct packed {
		logic [2:0] scl;
		logic [2:0] sda;
		isr_pins_type pins;
	} isr_watch_type;
endpackage : isr_pkg

/* verilog/isr_pin_watch.sv */
// Line synchroniser and bus edge, START and STOP detector
`timescale 1ns/1ps
`default_nettype none
module isr_pin_watch
	import isr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Bus lines
	input wire logic scl_pin,
	input wire logic sda_pin,
	// Events
	output isr_pins_type pins
);
	isr_watch_type st;
	isr_watch_type next_st;

	always_comb begin
		next_st = st;
		next_st.scl = {st.scl[1:0], scl_pin};
		next_st.sda = {st.sda[1:0], sda_pin};
		next_st.pins.scl = st.scl[1];
		next_st.pins.sda = st.sda[1];
		next_st.pins.scl_rise = st.scl[1] & ~st.scl[2];
		next_st.pins.scl_fall = ~st.scl[1] & st.scl[2];
		next_st.pins.start = st.scl[1] & st.scl[2] & ~st.sda[1] & st.sda[2];
		next_st.pins.stop = st.scl[1] & st.scl[2] & st.sda[1] & ~st.sda[2];
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st <= '{scl: 3'h7, sda: 3'h7, pins: '{scl: 1'b1, sda: 1'b1, default: 1'b0}};
		end else begin
			st <= next_st;
		end
	end

	assign pins = st.pins;
endmodule : isr_pin_watch
`default_nettype wire

/* testbench/isr_ctrl_props.sv */
// Port checker for the two-wire bus controller
`timescale 1ns/1ps
`default_nettype none
module isr_ctrl_props
	import isr_pkg::*;
(
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET,
	// Register bus
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	// Lines and interrupt
	input wire logic SCL_OUT,
	input wire logic SDA_OUT,
	input wire logic INTERRUPT_REQ
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	logic rd;
	logic rd_sr;
	logic wr_ctl;
	logic wr_rst;
	logic wr_any;
	assign rd = !AVS_WAITREQUEST && AVS_READ;
	assign rd_sr = rd && AVS_ADDRESS == ISR_OFS_SR;
	assign wr_ctl = !AVS_WAITREQUEST && AVS_WRITE && AVS_ADDRESS == ISR_OFS_CTL;
	assign wr_rst = !AVS_WAITREQUEST && AVS_WRITE && AVS_ADDRESS == ISR_OFS_SRR;
	assign wr_any = wr_ctl || wr_rst;
	////////////////////////////////////////////////////////////////
	wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low for more than one cycle");
	answer_next_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("access not answered in one cycle");
	upper_zero_a: assert property (rd |-> AVS_READDATA[31:8] == 24'h0)
		else $error("read data above the byte not zero");
	unmapped_zero_a: assert property (rd && AVS_ADDRESS > ISR_OFS_SR |-> AVS_READDATA == 32'h0)
		else $error("write-only or unmapped read not zero");
	idle_code_a: assert property (rd_sr && !INTERRUPT_REQ && !$past(INTERRUPT_REQ) |-> AVS_READDATA[7:0] == ISR_SC_NONE)
		else $error("status not idle code with flag clear");
	busy_code_a: assert property (rd_sr && INTERRUPT_REQ && $past(INTERRUPT_REQ) |-> AVS_READDATA[7:0] != ISR_SC_NONE)
		else $error("status idle code with flag set");
	flag_clear_a: assert property (wr_ctl && !AVS_WRITEDATA[ISR_CTL_FLAG] |-> ##[1:3] !INTERRUPT_REQ)
		else $error("interrupt not dropped after flag clear");
	soft_reset_a: assert property (wr_rst |-> ##[1:3] !INTERRUPT_REQ)
		else $error("interrupt not dropped after soft reset");
	flag_hold_a: assert property ($fell(INTERRUPT_REQ) |-> $past(wr_any) || $past(wr_any, 2) || $past(wr_any, 3))
		else $error("interrupt dropped without software");
	lines_low_a: assert property (!SCL_OUT && !SDA_OUT)
		else $error("line driven high");
	cover property ($rose(INTERRUPT_REQ));
	cover property (rd_sr && INTERRUPT_REQ);
	cover property (wr_rst ##[1:3] $fell(INTERRUPT_REQ));
endmodule : isr_ctrl_props
bind isr_ctrl isr_ctrl_props i_isr_ctrl_props (.SYS_CLK(SYS_CLK), .RESET(RESET),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .SCL_OUT(SCL_OUT), .SDA_OUT(SDA_OUT),
	.INTERRUPT_REQ(INTERRUPT_REQ));
`default_nettype wire

/* testbench/isr_bus_master.sv */
// Bus master model on the two-wire link, open-drain pulls only
`timescale 1ns/1ps
`default_nettype none
module isr_bus_master (
	// Clock and wire levels
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	// Pulls, high pulls the wire low
	output logic scl_low,
	output logic sda_low
);
	initial begin
		scl_low = 1'h0;
		sda_low = 1'h0;
	end
	// Half of a 160 ns link period
	task half;
		repeat (16) @(posedge clk);
	endtask : half
	// Release clock, wait out stretching, hold high one half
	task rise;
		scl_low <= 1'h0;
		@(posedge clk);
		while (!scl) @(posedge clk);
		half;
	endtask : rise
	task start;
		half;
		sda_low <= 1'h1;
		half;
		scl_low <= 1'h1;
		half;
	endtask : start
	task stop;
		sda_low <= 1'h1;
		half;
		rise;
		sda_low <= 1'h0;
		half;
	endtask : stop
	// Nine bits MSB first; r holds what the wire showed
	task xfer(input logic [7:0] d, input logic a, output logic [8:0] r);
		logic [8:0] s;
		s = {d, a};
		for (int i = 8; i >= 0; i--) begin
			sda_low <= !s[i];
			half;
			rise;
			r[i] = sda;
			scl_low <= 1'h1;
			half;
		end
	endtask : xfer
endmodule : isr_bus_master
`default_nettype wire

/* testbench/isr_ctrl_test.sv */
// Self-checking bench for the two-wire bus controller
`timescale 1ns/1ps
`default_nettype none
module isr_ctrl_test
	import isr_pkg::*;
;
	logic sys_clk = 1'h0;
	logic reset = 1'h1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic scl_out;
	logic scl_oe_n;
	logic sda_out;
	logic sda_oe_n;
	logic irq;
	logic m_scl;
	logic m_sda;
	logic scl;
	logic sda;
	logic [7:0] rv;
	logic [8:0] r;
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;
	// Pulled-up wires
	assign scl = !m_scl && (scl_oe_n || scl_out);
	assign sda = !m_sda && (sda_oe_n || sda_out);
	always #2.5 sys_clk = ~sys_clk;
	isr_ctrl i_isr_ctrl (.SYS_CLK(sys_clk), .RESET(reset), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .SCL_IN(scl),
		.SCL_OUT(scl_out), .SCL_OE_N(scl_oe_n), .SDA_IN(sda), .SDA_OUT(sda_out),
		.SDA_OE_N(sda_oe_n), .INTERRUPT_REQ(irq));
	isr_bus_master i_isr_bus_master (.clk(sys_clk), .scl(scl), .sda(sda),
		.scl_low(m_scl), .sda_low(m_sda));
	////////////////////////////////////////////////////////////////
	task complete_run;
		if (mismatches == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	task access(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= !w;
		avs_write <= w;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'h0) @(posedge sys_clk);
		rv = avs_readdata[7:0];
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask : access
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		access(1'h1, a, d);
	endtask : wr
	task rchk(input logic [7:0] a, input logic [7:0] e);
		access(1'h0, a, 8'h00);
		chk(rv, e);
	endtask : rchk
	task ack(input logic e);
		chk({7'h00, r[0]}, {7'h00, e});
	endtask : ack
	task bus_start;
		i_isr_bus_master.start;
	endtask : bus_start
	task bus_stop;
		i_isr_bus_master.stop;
	endtask : bus_stop
	task bus_byte(input logic [7:0] d, input logic a);
		i_isr_bus_master.xfer(d, a, r);
	endtask : bus_byte
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			mismatches++;
			complete_run;
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge sys_clk);
		reset <= 1'h0;
		rchk(ISR_OFS_SAR, 8'h00);
		rchk(ISR_OFS_XSAR, 8'h00);
		rchk(ISR_OFS_DR, 8'h00);
		rchk(ISR_OFS_CTL, 8'h00);
		rchk(ISR_OFS_SR, 8'hF8);
		wr(ISR_OFS_SR, 8'h00);
		rchk(ISR_OFS_SR, 8'hF8);
		rchk(ISR_OFS_CCR, 8'h00);
		rchk(8'h1C, 8'h00);
		wr(ISR_OFS_SAR, 8'hA5);
		rchk(ISR_OFS_SAR, 8'hA5);
		wr(ISR_OFS_CTL, 8'h04);
		// Own address with write, one data byte, stop
		bus_start;
		bus_byte(8'hA4, 1'h1);
		ack(1'h0);
		rchk(ISR_OFS_SR, 8'h60);
		rchk(ISR_OFS_CTL, 8'h0C);
		chk({7'h00, irq}, 8'h01);
		wr(ISR_OFS_CTL, 8'h04);
		rchk(ISR_OFS_SR, 8'hF8);
		bus_byte(8'h96, 1'h1);
		ack(1'h0);
		rchk(ISR_OFS_SR, 8'h80);
		rchk(ISR_OFS_DR, 8'h96);
		wr(ISR_OFS_CTL, 8'h04);
		bus_stop;
		rchk(ISR_OFS_SR, 8'hA0);
		wr(ISR_OFS_CTL, 8'h04);
		// General call, then acknowledge withdrawn
		bus_start;
		bus_byte(8'h00, 1'h1);
		rchk(ISR_OFS_SR, 8'h70);
		wr(ISR_OFS_CTL, 8'h04);
		bus_byte(8'h3C, 1'h1);
		rchk(ISR_OFS_SR, 8'h90);
		wr(ISR_OFS_CTL, 8'h00);
		bus_byte(8'hC3, 1'h1);
		ack(1'h1);
		rchk(ISR_OFS_SR, 8'h98);
		wr(ISR_OFS_CTL, 8'h04);
		bus_stop;
		// Address differing only in its first bit
		bus_start;
		bus_byte(8'h24, 1'h1);
		ack(1'h1);
		bus_stop;
		rchk(ISR_OFS_SR, 8'hF8);
		// Ten-bit address, then soft reset while held
		wr(ISR_OFS_SAR, 8'hF4);
		wr(ISR_OFS_XSAR, 8'h5A);
		bus_start;
		bus_byte(8'hF4, 1'h1);
		ack(1'h0);
		rchk(ISR_OFS_SR, 8'hF8);
		bus_byte(8'h5A, 1'h1);
		ack(1'h0);
		rchk(ISR_OFS_SR, 8'h60);
		wr(ISR_OFS_SRR, 8'h00);
		rchk(ISR_OFS_CTL, 8'h04);
		bus_stop;
		// Slave transmit: acked byte, last byte, then nack
		wr(ISR_OFS_SAR, 8'hA4);
		bus_start;
		bus_byte(8'hA5, 1'h1);
		rchk(ISR_OFS_SR, 8'hA8);
		wr(ISR_OFS_DR, 8'hC3);
		wr(ISR_OFS_CTL, 8'h04);
		bus_byte(8'hFF, 1'h0);
		chk(r[8:1], 8'hC3);
		rchk(ISR_OFS_SR, 8'hB8);
		wr(ISR_OFS_DR, 8'h3C);
		wr(ISR_OFS_CTL, 8'h00);
		bus_byte(8'hFF, 1'h0);
		rchk(ISR_OFS_SR, 8'hC8);
		wr(ISR_OFS_CTL, 8'h00);
		bus_stop;
		bus_start;
		bus_byte(8'hA5, 1'h1);
		ack(1'h1);
		bus_stop;
		wr(ISR_OFS_CTL, 8'h04);
		bus_start;
		bus_byte(8'hA5, 1'h1);
		wr(ISR_OFS_CTL, 8'h04);
		bus_byte(8'hFF, 1'h1);
		chk(r[8:1], 8'h3C);
		rchk(ISR_OFS_SR, 8'hC0);
		wr(ISR_OFS_CTL, 8'h04);
		bus_stop;
		complete_run;
	end
endmodule : isr_ctrl_test
`default_nettype wire
